//--- design/dem_pkg.sv
// constants for the dma event channel map
package dem_pkg;
    localparam int NUM_CH = 64;
    localparam int GPIO_LINES = 8;
    localparam int GPIO_BANKS = 7;
    localparam int PULSE_GENS = 4;
    localparam int SEL_W = 3;
    // fixed channel positions
    localparam int CH_AUDIO_TX = 8;
    localparam int CH_AUDIO_RX = 9;
    localparam int CH_UART_B_RX = 20;
    localparam int CH_UART_B_TX = 21;
    localparam int CH_UART_C_RX = 22;
    localparam int CH_UART_C_TX = 23;
    localparam int CH_UNUSED_24 = 24;
    localparam int CH_GPIO9 = 25;
    localparam int CH_CARD_A_RX = 26;
    localparam int CH_CARD_A_TX = 27;
    localparam int CH_TWI_RX = 28;
    localparam int CH_TWI_TX = 29;
    localparam int CH_CARD_B_RX = 30;
    localparam int CH_CARD_B_TX = 31;
    localparam int CH_GPIO_BASE = 32;
    localparam int CH_BANK_BASE = 40;
    localparam int CH_GPIO8 = 47;
    localparam int CH_TIMER_A_LO = 48;
    localparam int CH_TIMER_A_HI = 49;
    localparam int CH_TIMER_B_LO = 50;
    localparam int CH_TIMER_B_HI = 51;
    localparam int CH_PULSE_BASE = 52;
    localparam int CH_UNUSED_BASE = 56;
    // source select bit positions
    localparam int SEL_CH26_STICK = 0;
    localparam int SEL_CH8_TIMER = 1;
    localparam int SEL_CH9_TIMER = 2;
    // reset values
    localparam logic [63:0] PEND_RESET = 64'h0000_0000_0000_0000;
    localparam logic [63:0] EVT_RESET = 64'h0000_0000_0000_0000;
endpackage : dem_pkg

//--- design/dem_pend_if.sv
// carrier between the event map and its pending latch
`timescale 1ns/1ps
interface dem_pend_if #(parameter int N = 64);
    logic [N-1:0] set_req;
    logic [N-1:0] clear_req;
    logic [N-1:0] pending;
    modport mapper (output set_req, output clear_req, input pending);
    modport latch (input set_req, input clear_req, output pending);
endinterface : dem_pend_if

//--- design/dem_pending_latch.sv
// pending-event latch, one sticky bit per channel
`timescale 1ns/1ps
module dem_pending_latch #(
    parameter int N = 64
) (
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // set, clear and state
    dem_pend_if.latch pend
);
    logic [N-1:0] pending_r;
    logic [N-1:0] pending_nxt;

    // set wins over a clear in the same cycle
    always_comb begin
        pending_nxt = (pending_r & ~pend.clear_req) | pend.set_req;
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            pending_r <= dem_pkg::PEND_RESET[N-1:0];
        end else begin
            pending_r <= pending_nxt;
        end
    end

    assign pend.pending = pending_r;
endmodule : dem_pending_latch

//--- design/dem_event_map.sv
// fixed map of peripheral sync events onto the 64 dma channels
// Functional notes
// - second uart rx/tx to channels 20, 21
// - third uart rx/tx to channels 22, 23
// - gpio line 9 event to channel 25
// - channel 26 card a rx or stick; 27 tx
// - two-wire to 28, 29; card b to 30, 31
// - gpio lines 0-7 to 32-39; line 8 to 47
// - gpio banks 0-6 to channels 40-46
// - timers to 48-51, pulse generators to 52-55
// - every channel also triggered by chain events
// - source select picks each shared channel source
// - fixed map, only shared channels selectable
// - pending bit latches even when channel disabled
// - channels 8, 9 audio port or third timer
`timescale 1ns/1ps
module dem_event_map #(
    parameter int N = dem_pkg::NUM_CH
) (
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // events of channels 0-7 and 10-19, passed straight through
    input wire logic [7:0] early_event_lo,
    input wire logic [9:0] early_event_hi,
    // shared sources of channels 8 and 9
    input wire logic audio_port_tx_request,
    input wire logic audio_port_rx_request,
    input wire logic timer_c_low_event,
    input wire logic timer_c_high_event,
    // uarts
    input wire logic uart_rx_dma_request,
    input wire logic uart_b_tx_dma_request,
    input wire logic uart_c_rx_dma_request,
    input wire logic uart_c_tx_dma_request,
    // memory cards and stick
    input wire logic card_a_rx_request,
    input wire logic card_a_tx_request,
    input wire logic memory_stick_request,
    input wire logic card_b_rx_request,
    input wire logic card_b_tx_request,
    // two-wire bus
    input wire logic two_wire_rx_request,
    input wire logic two_wire_tx_request,
    // general-purpose i/o
    input wire logic [dem_pkg::GPIO_LINES-1:0] gpio_line_event,
    input wire logic gpio_line8_event,
    input wire logic gpio_line9_event,
    input wire logic [dem_pkg::GPIO_BANKS-1:0] gpio_bank_event,
    // timers and pulse generators
    input wire logic timer_a_low_event,
    input wire logic timer_a_high_event,
    input wire logic timer_b_low_event,
    input wire logic timer_b_high_event,
    input wire logic [dem_pkg::PULSE_GENS-1:0] pulse_gen_event,
    // channel controller side
    input wire logic [dem_pkg::SEL_W-1:0] dma_source_select,
    input wire logic [N-1:0] event_enable_reg,
    input wire logic [N-1:0] chain_event,
    input wire logic [N-1:0] pending_clear,
    // results
    output logic [N-1:0] channel_event,
    output logic [N-1:0] pending_event_reg,
    output logic [N-1:0] channel_trigger
);
    logic [N-1:0] mapped;
    logic [N-1:0] reserved;
    logic [N-1:0] event_set;
    logic [N-1:0] channel_event_r;
    logic [N-1:0] channel_event_nxt;
    logic [N-1:0] channel_trigger_r;
    logic [N-1:0] channel_trigger_nxt;
    logic ch26_alt;
    logic ch8_alt;
    logic ch9_alt;

    dem_pend_if #(.N(N)) pend ();

    // pick one of two sources by a select bit
    function automatic logic pick(input logic sel, input logic a,
                                  input logic b);
        pick = sel ? b : a;
    endfunction : pick

    // high now and low in the registered copy
    function automatic logic [N-1:0] rising(input logic [N-1:0] now,
                                             input logic [N-1:0] was);
        rising = now & ~was;
    endfunction : rising

    // channels with no peripheral source behind them
    function automatic logic [N-1:0] unused_mask();
        unused_mask = '0;
        unused_mask[dem_pkg::CH_UNUSED_24] = 1'b1;
        for (int i = dem_pkg::CH_UNUSED_BASE; i < N; i++) begin
            unused_mask[i] = 1'b1;
        end
    endfunction : unused_mask

    // shared channel selects, 1 picks the alternate source
    always_comb begin
        ch26_alt = dma_source_select[dem_pkg::SEL_CH26_STICK];
        ch8_alt = dma_source_select[dem_pkg::SEL_CH8_TIMER];
        ch9_alt = dma_source_select[dem_pkg::SEL_CH9_TIMER];
    end

    // fixed event to channel wiring; no other software control
    always_comb begin
        mapped = '0;
        // channels outside this map pass straight through
        mapped[7:0] = early_event_lo;
        mapped[19:10] = early_event_hi;
        // shared channels
        mapped[dem_pkg::CH_AUDIO_TX] = pick(ch8_alt,
            audio_port_tx_request, timer_c_low_event);
        mapped[dem_pkg::CH_AUDIO_RX] = pick(ch9_alt,
            audio_port_rx_request, timer_c_high_event);
        // uarts
        mapped[dem_pkg::CH_UART_B_RX] = uart_rx_dma_request;
        mapped[dem_pkg::CH_UART_B_TX] = uart_b_tx_dma_request;
        mapped[dem_pkg::CH_UART_C_RX] = uart_c_rx_dma_request;
        mapped[dem_pkg::CH_UART_C_TX] = uart_c_tx_dma_request;
        // memory cards and stick
        mapped[dem_pkg::CH_CARD_A_RX] = pick(ch26_alt,
            card_a_rx_request, memory_stick_request);
        mapped[dem_pkg::CH_CARD_A_TX] = card_a_tx_request;
        mapped[dem_pkg::CH_CARD_B_RX] = card_b_rx_request;
        mapped[dem_pkg::CH_CARD_B_TX] = card_b_tx_request;
        // two-wire bus
        mapped[dem_pkg::CH_TWI_RX] = two_wire_rx_request;
        mapped[dem_pkg::CH_TWI_TX] = two_wire_tx_request;
        // general-purpose i/o
        mapped[dem_pkg::CH_GPIO9] = gpio_line9_event;
        mapped[dem_pkg::CH_GPIO_BASE +: dem_pkg::GPIO_LINES] =
            gpio_line_event;
        mapped[dem_pkg::CH_GPIO8] = gpio_line8_event;
        mapped[dem_pkg::CH_BANK_BASE +: dem_pkg::GPIO_BANKS] =
            gpio_bank_event;
        // timers and pulse generators
        mapped[dem_pkg::CH_TIMER_A_LO] = timer_a_low_event;
        mapped[dem_pkg::CH_TIMER_A_HI] = timer_a_high_event;
        mapped[dem_pkg::CH_TIMER_B_LO] = timer_b_low_event;
        mapped[dem_pkg::CH_TIMER_B_HI] = timer_b_high_event;
        mapped[dem_pkg::CH_PULSE_BASE +: dem_pkg::PULSE_GENS] =
            pulse_gen_event;
    end

    // reserved channels stay quiet whatever lands on them
    always_comb begin
        reserved = unused_mask();
        channel_event_nxt = mapped & ~reserved;
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            channel_event_r <= dem_pkg::EVT_RESET[N-1:0];
        end else begin
            channel_event_r <= channel_event_nxt;
        end
    end

    // a rising mapped level or any chain cycle sets pending,
    // whatever the enable says; a held level sets it once
    always_comb begin
        event_set = rising(channel_event_nxt, channel_event_r);
        pend.set_req = event_set | chain_event;
        pend.clear_req = pending_clear;
    end

    // trigger where pending and enabled; pending is cleared only
    // by reset or by the controller once the channel is served
    always_comb begin
        channel_trigger_nxt = pend.pending & event_enable_reg;
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            channel_trigger_r <= dem_pkg::PEND_RESET[N-1:0];
        end else begin
            channel_trigger_r <= channel_trigger_nxt;
        end
    end

    dem_pending_latch #(.N(N)) u_pending (
        .clock(clock),
        .reset_n(reset_n),
        .pend(pend)
    );

    assign channel_event = channel_event_r;
    assign pending_event_reg = pend.pending;
    assign channel_trigger = channel_trigger_r;
endmodule : dem_event_map

//--- sim/dem_event_src.sv
// far-side event sources, one line per channel plus alternates
`timescale 1ns/1ps
module dem_event_src (
    // wanted channel events and alternate picks
    input wire logic [63:0] want,
    input wire logic [2:0] alt,
    // source lines by channel and alternate lines
    output logic [63:0] src,
    output logic [2:0] asrc
);
    always_comb begin
        src = want;
        src[26] = want[26] & ~alt[0];
        src[8] = want[8] & ~alt[1];
        src[9] = want[9] & ~alt[2];
        asrc = {want[9], want[8], want[26]} & alt;
    end
endmodule : dem_event_src

//--- sim/dem_event_map_properties.sv
// assertions on the event map ports
`timescale 1ns/1ps
module dem_event_map_properties #(
    parameter int N = 64
) (
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // sources
    input wire logic uart_rx_dma_request,
    input wire logic card_a_rx_request,
    input wire logic memory_stick_request,
    input wire logic [7:0] gpio_line_event,
    input wire logic [3:0] pulse_gen_event,
    input wire logic [2:0] dma_source_select,
    input wire logic [N-1:0] event_enable_reg,
    input wire logic [N-1:0] chain_event,
    // results
    input wire logic [N-1:0] channel_event,
    input wire logic [N-1:0] pending_event_reg,
    input wire logic [N-1:0] channel_trigger
);
    default clocking @(posedge clock);
    endclocking
    default disable iff (!reset_n);
    AST_UART_RX: assert property ($past(reset_n) |->
        channel_event[20] == $past(uart_rx_dma_request)) else $error("ch20");
    AST_RESERVED: assert property (
        channel_event[24] == 1'b0 && channel_event[63:56] == 8'h00)
        else $error("reserved active");
    AST_CARD_MUX: assert property ($past(reset_n) |->
        channel_event[26] == ($past(dma_source_select[0]) ?
        $past(memory_stick_request) : $past(card_a_rx_request)))
        else $error("ch26 pick");
    AST_GPIO: assert property ($past(reset_n) |->
        channel_event[39:32] == $past(gpio_line_event)) else $error("gpio");
    AST_PULSE: assert property ($past(reset_n) |->
        channel_event[55:52] == $past(pulse_gen_event)) else $error("pulse");
    AST_CHAIN: assert property ($past(reset_n) |->
        (pending_event_reg & $past(chain_event)) == $past(chain_event))
        else $error("chain not latched");
    AST_LATCH: assert property (
        $rose(uart_rx_dma_request) && !event_enable_reg[20]
        |=> pending_event_reg[20]) else $error("disabled not latched");
    AST_TRIG: assert property ($past(reset_n) |->
        channel_trigger == ($past(pending_event_reg) &
        $past(event_enable_reg))) else $error("trigger");
endmodule : dem_event_map_properties
bind dem_event_map dem_event_map_properties #(.N(N)) chk (.*);

//--- sim/dem_event_map_test.sv
// self-checking bench for the event map
`timescale 1ns/1ps
module dem_event_map_test;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic [63:0] want = 64'h0, en = 64'h0, chain = 64'h0, clr = 64'h0;
    logic [2:0] alt = 3'h0, sel = 3'h0, asrc;
    logic [63:0] src, channel_event, pending_event_reg, channel_trigger;
    int err_count = 0, tests_run = 0, cycles = 0;
    // channel, alternate driven, select, hit
    int rows [10][4] = '{'{26, 0, 0, 1}, '{26, 1, 1, 1}, '{26, 1, 0, 0},
        '{26, 0, 1, 0}, '{8, 0, 0, 1}, '{8, 2, 2, 1}, '{8, 2, 0, 0},
        '{9, 0, 0, 1}, '{9, 4, 4, 1}, '{9, 0, 4, 0}};
    dem_event_src src_model (.want(want), .alt(alt), .src(src), .asrc(asrc));
    dem_event_map dut (.clock(clock), .reset_n(reset_n),
        .early_event_lo(src[7:0]), .early_event_hi(src[19:10]),
        .audio_port_tx_request(src[8]), .audio_port_rx_request(src[9]),
        .timer_c_low_event(asrc[1]), .timer_c_high_event(asrc[2]),
        .uart_rx_dma_request(src[20]), .uart_b_tx_dma_request(src[21]),
        .uart_c_rx_dma_request(src[22]), .uart_c_tx_dma_request(src[23]),
        .card_a_rx_request(src[26]), .card_a_tx_request(src[27]),
        .memory_stick_request(asrc[0]), .card_b_rx_request(src[30]),
        .card_b_tx_request(src[31]), .two_wire_rx_request(src[28]),
        .two_wire_tx_request(src[29]), .gpio_line_event(src[39:32]),
        .gpio_line8_event(src[47]), .gpio_line9_event(src[25]),
        .gpio_bank_event(src[46:40]), .timer_a_low_event(src[48]),
        .timer_a_high_event(src[49]), .timer_b_low_event(src[50]),
        .timer_b_high_event(src[51]), .pulse_gen_event(src[55:52]),
        .dma_source_select(sel), .event_enable_reg(en), .chain_event(chain),
        .pending_clear(clr), .channel_event(channel_event),
        .pending_event_reg(pending_event_reg),
        .channel_trigger(channel_trigger));
    always #25 clock = ~clock;
    task automatic chk(logic [63:0] got, logic [63:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task tally_and_finish;
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : tally_and_finish
    task automatic run(int c, int a, int s, bit h);
        want = 64'h1 << c;
        alt = a[2:0];
        sel = s[2:0];
        @(negedge clock);
        chk(channel_event, h ? want : 64'h0);
        chk(pending_event_reg, h ? want : 64'h0);
        want = 64'h0;
        clr = ~64'h0;
        @(negedge clock);
        clr = 64'h0;
        @(negedge clock);
    endtask : run
    always @(posedge clock) begin
        cycles++;
        if (cycles == 600) begin
            err_count++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (10) @(negedge clock);
        chk(channel_event | pending_event_reg | channel_trigger, 64'h0);
        $display("reset test done");
        reset_n = 1'b1;
        for (int c = 0; c < 64; c++)
            if (c != 8 && c != 9 && c != 26) run(c, 0, 0, c != 24 && c < 56);
        foreach (rows[i]) run(rows[i][0], rows[i][1], rows[i][2], rows[i][3]);
        $display("map and select tests done");
        want[20] = 1'b1;
        en[20] = 1'b1;
        repeat (2) @(negedge clock);
        chk(channel_trigger, 64'h1 << 20);
        clr[20] = 1'b1;
        @(negedge clock);
        clr[20] = 1'b0;
        @(negedge clock);
        chk(pending_event_reg, 64'h0);
        $display("held level test done");
        want = 64'h0;
        en = 64'h0;
        chain = 64'h8000_0000_0100_0000;
        clr[63] = 1'b1;
        @(negedge clock);
        chk(pending_event_reg, 64'h8000_0000_0100_0000);
        chk(channel_event, 64'h0);
        chain = 64'h0;
        clr = 64'h0;
        reset_n = 1'b0;
        @(negedge clock);
        chk(pending_event_reg | channel_trigger, 64'h0);
        reset_n = 1'b1;
        $display("chain and reset tests done");
        tally_and_finish();
    end
endmodule : dem_event_map_test
